// ### hdl/spfm_top.sv
// Four-mode serial port with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
module spfm_top
    import spfm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        timer1_ovf,
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe,
    output logic             txd
);

    spfm_ctrl_t     ctrl_q;
    spfm_mode_t     mode;
    spfm_m0_state_t m0_state_q;
    spfm_ra_state_t ra_state_q;
    spfm_frame_t    frame;

    logic       ack_q;
    logic [31:0] dat_q;
    logic       fe_q;
    logic       ti_q;
    logic       ri_q;
    logic       rb8_q;
    logic [7:0] rx_buf_q;
    logic [7:0] slave_address_reg_q;
    logic [7:0] slave_address_mask_q;

    logic       rxd_meta_q;
    logic       rxd_sync_q;
    logic [3:0] mcyc_q;
    logic       state_one;
    logic [1:0] pre_q;
    logic       t1_half_q;
    logic       tick;
    logic [3:0] tx_div_q;
    logic       rollover;

    logic       tx_busy_q;
    logic       tx_pend_q;
    logic       tx_line_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_left_q;
    logic       tx_async_done;

    logic [3:0] m0_ph_q;
    logic [2:0] m0_bit_q;
    logic [7:0] m0_sh_q;
    logic       m0_sclk_q;
    logic       m0_ti_pend_q;
    logic       m0_ri_pend_q;
    logic       m0_tail_q;
    logic       m0_rx_load;
    logic [3:0] m0_per;

    logic [3:0] ra_cnt_q;
    logic [3:0] ra_bit_q;
    logic [1:0] ra_smp_q;
    logic       ra_prev_q;
    logic [7:0] ra_sh_q;
    logic       ra_ninth_q;
    logic       vote;

    logic       bus_req;
    logic       wr_ctrl;
    logic       wr_buf;
    logic       wr_pwr;
    logic       wr_slave_address_reg;
    logic       wr_slave_address_mask;
    logic [7:0] wbyte;
    logic       eleven;
    logic [3:0] frame_len;
    logic       ri_set;
    logic       ti_set;
    logic       fe_set;
    logic       rx_load;
    logic [7:0] bcast;
    logic       addr_hit;
    logic       rb8_cand;

    assign mode      = spfm_mode_t'({ctrl_q.mode_select_high, ctrl_q.mode_select_low});
    assign eleven    = ctrl_q.mode_select_high;
    assign frame_len = eleven ? SPFM_FRAME11 : SPFM_FRAME10;

    // Wishbone: one wait state, write lands on the acknowledge edge
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign wbyte    = wb_dat_i[7:0];
    assign wr_ctrl  = ack_q & bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == SPFM_OFS_CTRL);
    assign wr_buf   = ack_q & bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == SPFM_OFS_BUF);
    assign wr_pwr   = ack_q & bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == SPFM_OFS_PWR);
    assign wr_slave_address_reg = ack_q & bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == SPFM_OFS_SLAVE_ADDRESS_REG);
    assign wr_slave_address_mask = ack_q & bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == SPFM_OFS_SLAVE_ADDRESS_MASK);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            dat_q <= SPFM_RST_WORD;
        end else begin
            ack_q <= bus_req & ~ack_q;
            dat_q <= SPFM_RST_WORD;
            if (bus_req & ~ack_q & ~wb_we_i) begin
                if (wb_adr_i == SPFM_OFS_CTRL) begin
                    dat_q[7:0] <= {(ctrl_q.flag_view_select ? fe_q : ctrl_q.mode_select_high),
                                   ctrl_q.mode_select_low, ctrl_q.addr_filter_on, ctrl_q.rx_allow,
                                   ctrl_q.tx_ninth_bit, rb8_q, ti_q, ri_q};
                end else if (wb_adr_i == SPFM_OFS_BUF) begin
                    dat_q[7:0] <= rx_buf_q;
                end else if (wb_adr_i == SPFM_OFS_PWR) begin
                    dat_q[SPFM_PWR_BAUD_DBL] <= ctrl_q.baud_double;
                    dat_q[SPFM_PWR_VIEW_SEL] <= ctrl_q.flag_view_select;
                end else if (wb_adr_i == SPFM_OFS_SLAVE_ADDRESS_REG) begin
                    dat_q[7:0] <= slave_address_reg_q;
                end else if (wb_adr_i == SPFM_OFS_SLAVE_ADDRESS_MASK) begin
                    dat_q[7:0] <= slave_address_mask_q;
                end else begin
                    dat_q <= SPFM_RST_WORD;
                end
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Control storage; the high mode bit and the frame error are separate bits
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_q  <= '0;
            slave_address_reg_q <= SPFM_RST_BYTE;
            slave_address_mask_q <= SPFM_RST_BYTE;
        end else begin
            if (wr_ctrl) begin
                if (!ctrl_q.flag_view_select) begin
                    ctrl_q.mode_select_high <= wbyte[SPFM_CTRL_MSEL_HI];
                end
                ctrl_q.mode_select_low <= wbyte[SPFM_CTRL_MSEL_LO];
                ctrl_q.addr_filter_on  <= wbyte[SPFM_CTRL_AFILT];
                ctrl_q.rx_allow        <= wbyte[SPFM_CTRL_RX_ALLOW];
                ctrl_q.tx_ninth_bit    <= wbyte[SPFM_CTRL_TX_NINTH];
            end
            if (wr_pwr) begin
                ctrl_q.baud_double      <= wbyte[SPFM_PWR_BAUD_DBL];
                ctrl_q.flag_view_select <= wbyte[SPFM_PWR_VIEW_SEL];
            end
            if (wr_slave_address_reg) begin
                slave_address_reg_q <= wbyte;
            end
            if (wr_slave_address_mask) begin
                slave_address_mask_q <= wbyte;
            end
        end
    end

    // Status flags: a hardware set in the same cycle as a software write wins
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ti_q <= 1'b0;
            ri_q <= 1'b0;
            fe_q <= 1'b0;
        end else begin
            if (ti_set) begin
                ti_q <= 1'b1;
            end else if (wr_ctrl) begin
                ti_q <= wbyte[SPFM_CTRL_TX_DONE];
            end
            if (ri_set) begin
                ri_q <= 1'b1;
            end else if (wr_ctrl) begin
                ri_q <= wbyte[SPFM_CTRL_RX_FULL];
            end
            if (fe_set) begin
                fe_q <= 1'b1;
            end else if (wr_ctrl && ctrl_q.flag_view_select) begin
                fe_q <= wbyte[SPFM_CTRL_MSEL_HI];
            end
        end
    end

    // Pin synchroniser; only the second stage is read
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rxd_meta_q <= 1'b1;
            rxd_sync_q <= 1'b1;
        end else begin
            rxd_meta_q <= rxd_in;
            rxd_sync_q <= rxd_meta_q;
        end
    end

    // Machine cycle phase; state one is phase zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mcyc_q <= 4'h0;
        end else if (mcyc_q == SPFM_MCYC_LAST) begin
            mcyc_q <= 4'h0;
        end else begin
            mcyc_q <= mcyc_q + 4'h1;
        end
    end
    assign state_one = (mcyc_q == 4'h0);

    // Sixteen-times bit-rate tick
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pre_q     <= 2'h0;
            t1_half_q <= 1'b0;
        end else begin
            pre_q <= pre_q + 2'h1;
            if (timer1_ovf) begin
                t1_half_q <= ~t1_half_q;
            end
        end
    end
    always_comb begin
        if (mode == SPFM_MODE_A11F) begin
            tick = ctrl_q.baud_double ? pre_q[0] : (pre_q == 2'h3);
        end else begin
            tick = timer1_ovf & (ctrl_q.baud_double | t1_half_q);
        end
    end

    // Free divide-by-16 counter paces the transmitter
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tx_div_q <= 4'h0;
        end else if (tick) begin
            tx_div_q <= tx_div_q + 4'h1;
        end
    end
    assign rollover = tick & (tx_div_q == SPFM_SLICE_LAST);

    // Async transmitter; a bit goes out at state one after each rollover
    assign tx_async_done = state_one & tx_pend_q & (tx_left_q == 4'h1);
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tx_busy_q <= 1'b0;
            tx_pend_q <= 1'b0;
            tx_line_q <= 1'b1;
            tx_sh_q   <= '1;
            tx_left_q <= 4'h0;
        end else if (wr_buf && mode != SPFM_MODE_SHIFT) begin
            tx_busy_q <= 1'b1;
            tx_pend_q <= 1'b0;
            tx_left_q <= frame_len;
            tx_sh_q   <= {1'b1, (eleven ? ctrl_q.tx_ninth_bit : 1'b1), wbyte, 1'b0};
        end else if (tx_busy_q) begin
            if (rollover) begin
                tx_pend_q <= 1'b1;
            end
            if (state_one && tx_pend_q) begin
                tx_pend_q <= rollover;
                tx_line_q <= tx_sh_q[0];
                tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                tx_left_q <= tx_left_q - 4'h1;
                if (tx_left_q == 4'h1) begin
                    tx_busy_q <= 1'b0;
                end
            end
        end else begin
            tx_line_q <= 1'b1;
        end
    end

    // Synchronous shift mode; one engine, half duplex
    assign m0_per     = ctrl_q.addr_filter_on ? SPFM_M0_PER_FAST : SPFM_M0_PER_SLOW;
    assign m0_rx_load = (m0_state_q == SPFM_M0_RX) && m0_tail_q && (m0_ph_q == {2'b00, m0_per[3:2]});
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            m0_state_q <= SPFM_M0_IDLE;
            m0_ph_q    <= 4'h0;
            m0_bit_q   <= 3'h0;
            m0_sh_q    <= SPFM_RST_BYTE;
            m0_sclk_q  <= 1'b1;
            m0_tail_q  <= 1'b0;
            rxd_out    <= 1'b1;
            rxd_oe     <= 1'b0;
        end else begin
            case (m0_state_q)
                SPFM_M0_IDLE: begin
                    m0_ph_q   <= 4'h0;
                    m0_bit_q  <= 3'h0;
                    m0_sclk_q <= 1'b1;
                    m0_tail_q <= 1'b0;
                    rxd_oe    <= 1'b0;
                    if (mode == SPFM_MODE_SHIFT && wr_buf) begin
                        m0_sh_q    <= wbyte;
                        m0_state_q <= SPFM_M0_TX;
                    end else if (mode == SPFM_MODE_SHIFT && ctrl_q.rx_allow && !ri_q && !m0_ri_pend_q) begin
                        m0_state_q <= SPFM_M0_RX;
                    end
                end
                SPFM_M0_TX, SPFM_M0_RX: begin
                    m0_ph_q <= (m0_ph_q == m0_per - 4'h1) ? 4'h0 : m0_ph_q + 4'h1;
                    if (m0_ph_q == 4'h0 && m0_state_q == SPFM_M0_TX) begin
                        rxd_out <= m0_sh_q[0];
                        rxd_oe  <= 1'b1;
                    end
                    if (m0_ph_q == {2'b00, m0_per[3:2]} && !m0_tail_q) begin
                        m0_sclk_q <= 1'b0;
                    end
                    // Synchroniser and clock-pin register delay each bit by a period, so it is
                    // latched at the next falling point; the last one in a tail period with no clock
                    if (m0_ph_q == {2'b00, m0_per[3:2]} && m0_state_q == SPFM_M0_RX &&
                        (m0_bit_q != 3'h0 || m0_tail_q)) begin
                        m0_sh_q <= {rxd_sync_q, m0_sh_q[7:1]};
                    end
                    if (m0_ph_q == {2'b00, m0_per[3:2]} + {1'b0, m0_per[3:1]}) begin
                        m0_sclk_q <= 1'b1;
                    end
                    if (m0_ph_q == m0_per - 4'h1) begin
                        if (m0_state_q == SPFM_M0_TX) begin
                            m0_sh_q <= {1'b1, m0_sh_q[7:1]};
                        end
                        m0_bit_q <= m0_bit_q + 3'h1;
                        if (m0_bit_q == SPFM_M0_LAST_BIT) begin
                            if (m0_state_q == SPFM_M0_TX) begin
                                m0_state_q <= SPFM_M0_IDLE;
                            end else begin
                                m0_tail_q <= 1'b1;
                            end
                        end
                    end
                    if (m0_rx_load) begin
                        m0_state_q <= SPFM_M0_IDLE;
                    end
                    if (mode != SPFM_MODE_SHIFT) begin
                        m0_state_q <= SPFM_M0_IDLE;
                    end
                end
                default: begin
                    m0_state_q <= SPFM_M0_IDLE;
                end
            endcase
        end
    end

    // Shift-mode flags wait for the next state one
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            m0_ti_pend_q <= 1'b0;
            m0_ri_pend_q <= 1'b0;
        end else begin
            if ((m0_state_q == SPFM_M0_TX) && (m0_ph_q == m0_per - 4'h1) && (m0_bit_q == SPFM_M0_LAST_BIT)) begin
                m0_ti_pend_q <= 1'b1;
            end else if (state_one) begin
                m0_ti_pend_q <= 1'b0;
            end
            if (m0_rx_load) begin
                m0_ri_pend_q <= 1'b1;
            end else if (state_one) begin
                m0_ri_pend_q <= 1'b0;
            end
        end
    end

    // Async receiver
    assign vote = (ra_smp_q[1] & ra_smp_q[0]) | (ra_smp_q[1] & rxd_sync_q) | (ra_smp_q[0] & rxd_sync_q);
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ra_state_q <= SPFM_RA_HUNT;
            ra_cnt_q   <= 4'h0;
            ra_bit_q   <= 4'h0;
            ra_smp_q   <= 2'b11;
            ra_prev_q  <= 1'b1;
            ra_sh_q    <= SPFM_RST_BYTE;
            ra_ninth_q <= 1'b1;
            frame      <= '0;
        end else begin
            frame.valid <= 1'b0;
            if (tick) begin
                ra_prev_q <= rxd_sync_q;
            end
            case (ra_state_q)
                SPFM_RA_HUNT: begin
                    if (tick && ctrl_q.rx_allow && mode != SPFM_MODE_SHIFT && ra_prev_q && !rxd_sync_q) begin
                        ra_cnt_q   <= 4'h1;
                        ra_bit_q   <= 4'h0;
                        ra_state_q <= SPFM_RA_RECV;
                    end
                end
                SPFM_RA_RECV: begin
                    if (tick) begin
                        ra_cnt_q <= ra_cnt_q + 4'h1;
                        if (ra_cnt_q >= SPFM_VOTE_S1 && ra_cnt_q < SPFM_VOTE_S3) begin
                            ra_smp_q <= {ra_smp_q[0], rxd_sync_q};
                        end
                        if (ra_cnt_q == SPFM_VOTE_S3) begin
                            ra_bit_q <= ra_bit_q + 4'h1;
                            if (ra_bit_q == 4'h0) begin
                                if (vote) begin
                                    ra_state_q <= SPFM_RA_HUNT;
                                end
                            end else if (ra_bit_q < 4'h9) begin
                                ra_sh_q <= {vote, ra_sh_q[7:1]};
                            end else if (ra_bit_q == 4'h9 && eleven) begin
                                ra_ninth_q <= vote;
                            end else begin
                                frame.valid <= 1'b1;
                                frame.data  <= ra_sh_q;
                                frame.ninth <= eleven ? ra_ninth_q : vote;
                                frame.stop  <= vote;
                                ra_state_q  <= SPFM_RA_HUNT;
                            end
                        end
                    end
                    if (mode == SPFM_MODE_SHIFT) begin
                        ra_state_q <= SPFM_RA_HUNT;
                    end
                end
                default: begin
                    ra_state_q <= SPFM_RA_HUNT;
                end
            endcase
        end
    end

    // Address recognition against Given and Broadcast addresses
    assign bcast    = slave_address_reg_q | slave_address_mask_q;
    assign addr_hit = (((frame.data ^ slave_address_reg_q) & slave_address_mask_q) == 8'h00) || ((frame.data & bcast) == bcast);
    assign rb8_cand = frame.ninth;
    assign rx_load  = frame.valid && !ri_q && (!ctrl_q.addr_filter_on || (rb8_cand && addr_hit));
    assign fe_set   = frame.valid && !frame.stop;
    assign ri_set   = rx_load || (state_one && m0_ri_pend_q);
    assign ti_set   = tx_async_done || (state_one && m0_ti_pend_q);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rx_buf_q <= SPFM_RST_BYTE;
            rb8_q    <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_buf_q <= frame.data;
                rb8_q    <= rb8_cand;
            end else if (m0_rx_load) begin
                rx_buf_q <= {rxd_sync_q, m0_sh_q[7:1]};
            end
            if (wr_ctrl && !rx_load) begin
                rb8_q <= wbyte[SPFM_CTRL_RX_NINTH];
            end
        end
    end

    // Pin mux: shift clock in shift mode, serial line otherwise
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            txd <= 1'b1;
        end else begin
            txd <= (mode == SPFM_MODE_SHIFT) ? m0_sclk_q : tx_line_q;
        end
    end

endmodule
`default_nettype wire

// ### hdl/spfm_pkg.sv
// Constants, register map and carrier types of the four-mode serial port
package spfm_pkg;

    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] SPFM_OFS_CTRL   = 8'h00;
    localparam logic [7:0] SPFM_OFS_BUF    = 8'h04;
    localparam logic [7:0] SPFM_OFS_PWR    = 8'h08;
    localparam logic [7:0] SPFM_OFS_SLAVE_ADDRESS_REG  = 8'h0C;
    localparam logic [7:0] SPFM_OFS_SLAVE_ADDRESS_MASK  = 8'h10;

    // Field positions in serial_control_reg
    localparam int SPFM_CTRL_MSEL_HI  = 7;
    localparam int SPFM_CTRL_MSEL_LO  = 6;
    localparam int SPFM_CTRL_AFILT    = 5;
    localparam int SPFM_CTRL_RX_ALLOW = 4;
    localparam int SPFM_CTRL_TX_NINTH = 3;
    localparam int SPFM_CTRL_RX_NINTH = 2;
    localparam int SPFM_CTRL_TX_DONE  = 1;
    localparam int SPFM_CTRL_RX_FULL  = 0;

    // Field positions in power_control_reg
    localparam int SPFM_PWR_BAUD_DBL  = 7;
    localparam int SPFM_PWR_VIEW_SEL  = 6;

    // Reset values
    localparam logic [7:0] SPFM_RST_BYTE  = 8'h00;
    localparam logic [31:0] SPFM_RST_WORD = 32'h0000_0000;

    // Timing counts in clocks and bit slices
    localparam logic [3:0] SPFM_MCYC_LAST   = 4'hB;  // 12 clocks per machine cycle
    localparam logic [3:0] SPFM_M0_PER_SLOW = 4'hC;  // Shift clock at 1/12
    localparam logic [3:0] SPFM_M0_PER_FAST = 4'h4;  // Shift clock at 1/4
    localparam logic [3:0] SPFM_SLICE_LAST  = 4'hF;  // 16 slices per bit
    localparam logic [3:0] SPFM_VOTE_S1     = 4'h7;  // 8th slice
    localparam logic [3:0] SPFM_VOTE_S3     = 4'h9;  // 10th slice
    localparam logic [3:0] SPFM_FRAME10     = 4'hA;
    localparam logic [3:0] SPFM_FRAME11     = 4'hB;
    localparam logic [2:0] SPFM_M0_LAST_BIT = 3'h7;

    // Operating modes
    typedef enum logic [1:0] {
        SPFM_MODE_SHIFT = 2'h0,
        SPFM_MODE_A10   = 2'h1,
        SPFM_MODE_A11F  = 2'h2,
        SPFM_MODE_A11T  = 2'h3
    } spfm_mode_t;

    typedef enum logic [2:0] {
        SPFM_M0_IDLE = 3'b001,
        SPFM_M0_TX   = 3'b010,
        SPFM_M0_RX   = 3'b100
    } spfm_m0_state_t;

    typedef enum logic [1:0] {
        SPFM_RA_HUNT = 2'b01,
        SPFM_RA_RECV = 2'b10
    } spfm_ra_state_t;

    // Software-written control fields
    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic addr_filter_on;
        logic rx_allow;
        logic tx_ninth_bit;
        logic baud_double;
        logic flag_view_select;
    } spfm_ctrl_t;

    // Result of one received frame
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       ninth;
        logic       stop;
    } spfm_frame_t;

endpackage

// ### bench/spfm_props.sv
// Bus and line checks bound to the serial port
`timescale 1ns/1ps
`default_nettype none
module spfm_props (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        txd
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_ack_quiet: assert property (!wb_cyc_i ##1 !wb_cyc_i |-> !wb_ack_o) else $error("ack on idle bus");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_hole_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h14) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_start_held: assert property ($fell(txd) |-> !txd [*2]) else $error("low bit too short");
    a_high_held: assert property ($rose(txd) |-> txd [*2]) else $error("high bit too short");
endmodule
bind spfm_top spfm_props spfm_props_inst (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .txd(txd));
`default_nettype wire

// ### bench/spfm_peer.sv
// Serial peer: async frames or shift-mode bytes into the port
`timescale 1ns/1ps
`default_nettype none
module spfm_peer (
    input  wire logic        mclk,
    input  wire logic        go,
    input  wire logic        sync,
    input  wire logic        shclk,
    input  wire logic [10:0] frm,
    input  wire logic [3:0]  nb,
    input  wire logic [7:0]  per,
    output logic             line
);
    int k;
    // Pulled-up line: high whenever the peer is not sending
    initial line = 1'b1;
    always @(posedge mclk) begin
        if (go && !sync) begin
            for (int i = 0; i < nb; i++) begin
                line <= frm[i];
                repeat (per) @(posedge mclk);
            end
            line <= 1'b1;
        end
    end
    always @(posedge go) k = 0;
    always @(negedge shclk) begin
        if (sync) begin
            line <= (k < 8) ? frm[k] : 1'b1;
            k++;
        end
    end
endmodule
`default_nettype wire

// ### bench/tb_spfm_top.sv
// Self-checking bench of the four-mode serial port
`timescale 1ns/1ps
`default_nettype none
module tb_spfm_top;
    import spfm_pkg::*;
    logic        mclk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, ovf, go, sync, line, rxd_out, rxd_oe, txd;
    logic [7:0]  wb_adr, per;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic [10:0] frm, ef, got;
    logic [3:0]  nb;
    logic [15:0] r;
    wire         rxd;
    int          num_errors, compares;
    // Rows: mode, {baud_double, filter, ninth or stop, expect full}, data
    logic [15:0] rows [7] = '{16'h1B5A, 16'h29C3, 16'h3FA0, 16'h3EA2, 16'h27FF, 16'h2CA0, 16'h17A5};
    spfm_top spfm_top_inst (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .timer1_ovf(ovf), .rxd_in(rxd), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
    spfm_peer spfm_peer_inst (.mclk(mclk), .go(go), .sync(sync), .shclk(txd), .frm(frm), .nb(nb),
        .per(per), .line(line));
    assign rxd = rxd_oe ? rxd_out : line;
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Overflow every second clock keeps timer-timed bits as long as fixed ones
    always @(posedge mclk) ovf <= ~ovf;
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge mclk);
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic send(input logic [3:0] c, input logic [10:0] f, input logic s);
        nb <= c;
        frm <= f;
        sync <= s;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        num_errors++;
        conclude();
    end
    initial begin
        {reset_n, wb_cyc, wb_stb, wb_we, go, sync, ovf} = 7'h0;
        wb_adr = 8'h0;
        wb_wdat = 32'h0;
        per = 8'h20;
        nb = 4'hA;
        frm = 11'h7FF;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        wb_xfer(1'b0, SPFM_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        wb_xfer(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb_xfer(1'b1, SPFM_OFS_SLAVE_ADDRESS_REG, 32'hA4);
        wb_xfer(1'b1, SPFM_OFS_SLAVE_ADDRESS_MASK, 32'hFA);
        foreach (rows[i]) begin
            r = rows[i];
            per <= r[11] ? 8'h20 : 8'h40;
            wb_xfer(1'b1, SPFM_OFS_PWR, {24'h0, r[11], 7'h0});
            wb_xfer(1'b1, SPFM_OFS_CTRL, {24'h0, r[13:12], r[10], 1'b1, r[9], 3'h0});
            wb_xfer(1'b1, SPFM_OFS_BUF, {24'h0, r[7:0]});
            ef = (r[13:12] == 2'h1) ? {2'h3, r[7:0], 1'b0} : {1'b1, r[9], r[7:0], 1'b0};
            send((r[13:12] == 2'h1) ? 4'hA : 4'hB, ef, 1'b0);
            got = 11'h7FF;
            while (txd) @(posedge mclk);
            repeat (per / 2) @(posedge mclk);
            for (int k = 0; k < nb; k++) begin
                got[k] = txd;
                repeat (per) @(posedge mclk);
            end
            chk("tx frame", ef, got);
            repeat (per) @(posedge mclk);
            wb_xfer(1'b0, SPFM_OFS_CTRL, 32'h0);
            chk("rx full", r[8], rd[0]);
            chk("tx done", 1'b1, rd[1]);
            if (r[8]) begin
                chk("rx ninth", r[9], rd[2]);
                wb_xfer(1'b0, SPFM_OFS_BUF, 32'h0);
                chk("rx data", r[7:0], rd);
            end
        end
        wb_xfer(1'b1, SPFM_OFS_CTRL, 32'h90);
        per <= 8'h20;
        wb_xfer(1'b1, SPFM_OFS_PWR, 32'hC0);
        send(4'hB, 11'h066, 1'b0);
        repeat (420) @(posedge mclk);
        wb_xfer(1'b0, SPFM_OFS_CTRL, 32'h0);
        chk("frame error", 1'b1, rd[7]);
        wb_xfer(1'b1, SPFM_OFS_CTRL, 32'h90);
        send(4'hB, 11'h466, 1'b0);
        repeat (420) @(posedge mclk);
        wb_xfer(1'b0, SPFM_OFS_CTRL, 32'h0);
        chk("error sticky", 32'h91, rd);
        wb_xfer(1'b1, SPFM_OFS_CTRL, 32'h10);
        wb_xfer(1'b1, SPFM_OFS_PWR, 32'h80);
        wb_xfer(1'b0, SPFM_OFS_CTRL, 32'h0);
        chk("mode high view", 1'b1, rd[7]);
        send(4'h8, 11'h096, 1'b1);
        wb_xfer(1'b1, SPFM_OFS_CTRL, 32'h30);
        repeat (60) @(posedge mclk);
        wb_xfer(1'b0, SPFM_OFS_BUF, 32'h0);
        chk("shift rx", 32'h96, rd);
        wb_xfer(1'b1, SPFM_OFS_BUF, 32'h5C);
        repeat (60) @(posedge mclk);
        wb_xfer(1'b0, SPFM_OFS_CTRL, 32'h0);
        chk("shift flags", 32'h33, rd);
        send(4'h8, 11'h0A3, 1'b1);
        wb_xfer(1'b1, SPFM_OFS_CTRL, 32'h10);
        repeat (150) @(posedge mclk);
        wb_xfer(1'b0, SPFM_OFS_BUF, 32'h0);
        chk("slow shift rx", 32'hA3, rd);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        chk("txd after reset", 1'b1, txd);
        chk("oe after reset", 1'b0, rxd_oe);
        wb_xfer(1'b0, SPFM_OFS_CTRL, 32'h0);
        chk("ctrl after reset", 32'h0, rd);
        conclude();
    end
endmodule
`default_nettype wire
